// File: bench/apr_servo_model.sv
// servo amplifier model: sends the absolute word two bits per step
// assumes mode and request from the controller, synchronous to aclk
`timescale 1ns/10ps
module apr_servo_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic abs_xfer_mode_out,
  input wire logic abs_request_out,
  input wire logic [31:0] abs_word,
  input wire logic [1:0] lag,
  output logic abs_data_lo_in,
  output logic abs_data_hi_in,
  output logic abs_data_ready_in
);
  logic [3:0] step_q = 4'h0;
  logic [1:0] cnt_q = 2'h0;
  logic rdy_q = 1'b0, lo_q = 1'b0, hi_q = 1'b0, tog_q = 1'b0;
  // data lines toggle while not valid
  assign abs_data_lo_in = rdy_q ? lo_q : tog_q;
  assign abs_data_hi_in = rdy_q ? hi_q : ~tog_q;
  assign abs_data_ready_in = rdy_q;
  always_ff @(posedge aclk) begin
    tog_q <= ~tog_q;
    if (!aresetn || !abs_xfer_mode_out) begin
      step_q <= 4'h0;
      cnt_q <= 2'h0;
      rdy_q <= 1'b0;
    end else if (abs_request_out != rdy_q) begin
      if (cnt_q != lag) begin
        cnt_q <= cnt_q + 2'h1;
      end else begin
        cnt_q <= 2'h0;
        rdy_q <= abs_request_out;
        if (abs_request_out) begin
          lo_q <= abs_word[{step_q, 1'b0}];
          hi_q <= abs_word[{step_q, 1'b1}];
        end else begin
          step_q <= step_q + 4'h1;
        end
      end
    end
  end
endmodule : apr_servo_model

// File: bench/test_apr_axis_ctrl.sv
// bench of the axis controller: bus master, restore handshake, motion commands
// assumes the package, design files and servo model compiled first
`timescale 1ns/10ps
module test_apr_axis_ctrl;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic servo_enable_out, abs_xfer_mode_out, abs_request_out;
  logic abs_data_lo_in, abs_data_hi_in, abs_data_ready_in;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, word = 32'h0, v, tg[2];
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp, lag = 2'h0;
  logic [31:0] eq[$], mq[$], e, m, rt[4];
  logic [1:0] bq[$], rq[$];
  int miscompares = 0, compares = 0, cyc = 0;
  always #5 aclk = ~aclk;
  apr_axis_ctrl #(.SOFF_CYCLES(20)) DUT (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .servo_enable_out, .abs_xfer_mode_out,
    .abs_request_out, .abs_data_lo_in, .abs_data_hi_in, .abs_data_ready_in);
  apr_servo_model amp (.aclk, .aresetn, .abs_xfer_mode_out, .abs_request_out,
    .abs_word(word), .lag, .abs_data_lo_in, .abs_data_hi_in, .abs_data_ready_in);
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] cmd(logic [3:0] op, logic ax, logic [3:0] a1, logic [3:0] a2);
    return {16'h0, a2, a1, 3'h0, ax, op};
  endfunction : cmd
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = apr_pkg::RESP_OKAY);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // mask zero means the read data is not compared, only the response
  task automatic rd(logic [7:0] a, logic [31:0] x = 32'h0, logic [31:0] k = 32'h0,
                    logic [1:0] r = apr_pkg::RESP_OKAY);
    eq.push_back(x);
    mq.push_back(k);
    rq.push_back(r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic poll(int b);
    int n;
    n = 0;
    do begin
      rd(apr_pkg::A_STAT);
      n++;
    end while (v[b] !== 1'b1 && n < 300);
    chk(32'(v[b]), 32'h1);
  endtask : poll
  task automatic go(logic [3:0] op, logic ax, logic [3:0] a1, logic [3:0] a2, int b);
    wr(apr_pkg::A_CMD, cmd(op, ax, a1, a2));
    poll(b);
    wr(apr_pkg::A_STAT, 32'hff);
  endtask : go
  always @(posedge aclk) begin
    cyc++;
    if (rvalid && rready) begin
      m = mq.pop_front();
      e = eq.pop_front();
      if (m != 32'h0) chk(rdata & m, e & m);
      chk(32'(rresp), 32'(rq.pop_front()));
    end
    if (bvalid && bready) chk(32'(bresp), 32'(bq.pop_front()));
    if (cyc == 60000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    void'($urandom(75));
    rt = '{32'h8000, 32'hffff8059, 32'h7fff, 32'hffff805a};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(apr_pkg::A_CTRL, 32'h0, '1);
    rd(apr_pkg::A_FB, 32'h2000, '1);
    rd(apr_pkg::A_TIDX, 32'h1, '1);
    rd(apr_pkg::A_STAT, 32'h0, '1);
    wr(8'h40, 32'h1, apr_pkg::RESP_SLVERR);
    rd(8'h40, 32'h0, '1, apr_pkg::RESP_SLVERR);
    wr(apr_pkg::A_POS1, 32'h1, apr_pkg::RESP_SLVERR);
    rd(apr_pkg::A_POS1, 32'h0, '1);
    wr(apr_pkg::A_CTRL, 32'h1);
    chk(32'(servo_enable_out), 32'h1);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      lag <= 2'(3 * i);
      word <= $urandom();
      wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_RESTORE, 1'b0, 4'h0, 4'h0));
      repeat (6) @(posedge aclk);
      chk(32'(servo_enable_out), 32'h0);
      poll(apr_pkg::ST_RST_DONE);
      chk(32'(abs_xfer_mode_out), 32'h0);
      rd(apr_pkg::A_ABS, word, '1);
      wr(apr_pkg::A_STAT, 32'hff);
    end
    $display("test restore done");
    wr(apr_pkg::A_SPD, 32'h1000_0000);
    for (int i = 0; i < 2; i++) begin
      tg[i] = $urandom();
      wr(apr_pkg::A_TIDX, 32'(1 + 9 * i));
      wr(apr_pkg::A_TDAT, tg[i]);
      go(apr_pkg::OP_TABLE, 1'b0, 4'(1 + 9 * i), 4'h0, apr_pkg::ST_DONE);
      rd(apr_pkg::A_POS1, tg[i], '1);
      go(apr_pkg::OP_TABLE, 1'b0, 4'(11 * i), 4'h0, apr_pkg::ST_ERR_ENTRY);
    end
    wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_DUAL, 1'b0, 4'h1, 4'ha));
    poll(apr_pkg::ST_DONE);
    poll(apr_pkg::ST_DONE + 1);
    rd(apr_pkg::A_POS1, tg[0], '1);
    rd(apr_pkg::A_POS2, tg[1], '1);
    wr(apr_pkg::A_STAT, 32'hff);
    $display("test table done");
    wr(apr_pkg::A_CTRL, 32'h3);
    wr(apr_pkg::A_FB, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(apr_pkg::A_TGT, rt[i]);
      go(apr_pkg::OP_DIRECT, 1'b1, 4'h0, 4'h0, i < 2 ? 5 : 7);
    end
    rd(apr_pkg::A_POS2, rt[3], '1);
    wr(apr_pkg::A_CTRL, 32'h1);
    $display("test range done");
    go(apr_pkg::OP_HOME, 1'b0, 4'h5, 4'h0, apr_pkg::ST_DONE);
    rd(apr_pkg::A_POS1, 32'h0, '1);
    rd(apr_pkg::A_STAT, 32'h500, 32'hf00);
    wr(apr_pkg::A_SPD, 32'h1);
    wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_JOG, 1'b0, 4'h0, 4'h0));
    rd(apr_pkg::A_STAT, 32'h1, 32'h1);
    wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_HALT, 1'b0, 4'h0, 4'h0));
    rd(apr_pkg::A_STAT, 32'h0, 32'h1);
    wr(apr_pkg::A_TGT, 32'd1000);
    wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_DIRECT, 1'b0, 4'h0, 4'h0));
    wr(apr_pkg::A_TGT, 32'd200);
    go(apr_pkg::OP_DEST, 1'b0, 4'h0, 4'h0, apr_pkg::ST_DONE);
    rd(apr_pkg::A_POS1, 32'd200, '1);
    wr(apr_pkg::A_TGT, 32'd100000);
    wr(apr_pkg::A_CMD, cmd(apr_pkg::OP_DIRECT, 1'b0, 4'h0, 4'h0));
    wr(apr_pkg::A_SPD, 32'h1000_0000);
    go(apr_pkg::OP_SPEED, 1'b0, 4'h0, 4'h0, apr_pkg::ST_DONE);
    rd(apr_pkg::A_POS1, 32'd100000, '1);
    $display("test motion done");
    give_verdict();
  end
endmodule : test_apr_axis_ctrl

// File: rtl/apr_axis_ctrl.sv
// two-axis positioning controller with absolute position restore handshake
// assumes AXI4-Lite master, amplifier pins synchronous to aclk
// How it works
// - transfer-mode output high puts amplifier pins into absolute transfer
// - in transfer mode, request output asks for each next data pair
// - servo-on output high while the amplifier should run normally
// - absolute mode: pulses from origin within -32678..32768 revs minus one
// - restore owns three input and three output pins exclusively
// - servo-on drops about 20 ms while a restore runs
// - table start runs preset entry 1..10 on chosen axis
// - direct start runs from target and speed registers, bypassing table
// - dual start launches both axes with their own table entries
// - origin return homes chosen axis using the given method; here it always moves to 0, the method only shows in status
// - jog command starts manual jog on chosen axis
// - halt command stops the moving axis
// - speed change alters velocity of a running axis
// - target change replaces destination of a running axis
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
module apr_axis_ctrl #(
  parameter int SOFF_CYCLES = apr_pkg::SOFF_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic servo_enable_out,
  output logic abs_xfer_mode_out,
  output logic abs_request_out,
  input wire logic abs_data_lo_in,
  input wire logic abs_data_hi_in,
  input wire logic abs_data_ready_in
);
  localparam int NA = apr_pkg::NAXES;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction : wmerge

  function automatic logic entry_ok(input logic [3:0] n);
    return n >= apr_pkg::ENTRY_MIN && n <= apr_pkg::ENTRY_MAX;
  endfunction : entry_ok

  function automatic logic pulse_ok(input logic en, input logic [31:0] t,
                                    input logic [15:0] fb);
    logic signed [48:0] tv;
    logic signed [48:0] lo;
    logic signed [48:0] hi;
    tv = 49'(signed'(t));
    lo = -(49'(apr_pkg::RANGE_NEG) * 49'(fb));
    hi = 49'(apr_pkg::RANGE_POS) * 49'(fb) - 49'h1;
    return !en || (tv >= lo && tv <= hi);
  endfunction : pulse_ok

  // bus slave state
  logic aw_have_q, w_have_q, wr_fire;
  logic [7:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_d;
  logic rd_ok;
  // software registers
  logic [1:0] ctrl_q;
  logic [15:0] cmd_q;
  logic [31:0] tgt_reg_q, spd_reg_q;
  logic [15:0] fb_q;
  logic [3:0] tidx_q;
  logic [3:0] home_mth_q;
  logic l1_q, l2_q;
  logic err_entry_q, err_range_q, rst_done_q;
  // table
  logic [31:0] mem_a, mem_b;
  // axes
  logic [31:0] pos_q [NA];
  logic [31:0] tgt_q [NA];
  logic [31:0] spd_q [NA];
  logic [NA-1:0] run_q, jog_q, jog_rev_q, done_q;
  logic [NA-1:0] start_ev, halt_ev, spd_ev, dst_ev, jog_ev, clr_done;
  logic [31:0] new_tgt [NA];
  logic err_entry_ev, err_range_ev, rst_go;
  // restore
  apr_pkg::apr_rst_state_t rst_state_q;
  logic [31:0] soff_cnt_q;
  logic [4:0] step_q;
  logic [31:0] abs_shift_q;
  logic rst_axis_q;
  logic rst_load;

  wire [3:0] op = cmd_q[apr_pkg::OP_LSB +: 4];
  wire ax = cmd_q[apr_pkg::AXIS_BIT];
  wire [3:0] arg = cmd_q[apr_pkg::ARG_LSB +: 4];
  wire [3:0] arg2 = cmd_q[apr_pkg::ARG2_LSB +: 4];
  wire abs_en = ctrl_q[apr_pkg::CTRL_ABS_EN];
  wire wr_stat = wr_fire && waddr_q == apr_pkg::A_STAT;

  assign wr_fire = aw_have_q && w_have_q && !bvalid && !l1_q && !l2_q;
  assign rst_load = rst_state_q == apr_pkg::R_LOAD;

  // write address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awready <= 1'b0;
      waddr_q <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awready <= 1'b0;
      waddr_q <= awaddr;
    end else if (wr_fire || !aw_have_q) begin
      aw_have_q <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wready <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wready <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_fire || !w_have_q) begin
      w_have_q <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= apr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= (waddr_q <= apr_pkg::A_TDAT && waddr_q[1:0] == 2'h0 && waddr_q != apr_pkg::A_ABS
                && waddr_q != apr_pkg::A_POS1 && waddr_q != apr_pkg::A_POS2)
               ? apr_pkg::RESP_OKAY : apr_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // software registers; a command write starts a two-cycle launch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= apr_pkg::CTRL_RST;
      cmd_q <= '0;
      tgt_reg_q <= '0;
      spd_reg_q <= '0;
      fb_q <= apr_pkg::FB_RST;
      tidx_q <= apr_pkg::ENTRY_MIN;
      l1_q <= 1'b0;
      l2_q <= 1'b0;
    end else begin
      l1_q <= wr_fire && waddr_q == apr_pkg::A_CMD;
      l2_q <= l1_q;
      if (wr_fire) begin
        case (waddr_q)
          apr_pkg::A_CTRL: ctrl_q <= 2'(wmerge(32'(ctrl_q), wdata_q, wstrb_q));
          apr_pkg::A_CMD: cmd_q <= 16'(wmerge(32'(cmd_q), wdata_q, wstrb_q));
          apr_pkg::A_TGT: tgt_reg_q <= wmerge(tgt_reg_q, wdata_q, wstrb_q);
          apr_pkg::A_SPD: spd_reg_q <= wmerge(spd_reg_q, wdata_q, wstrb_q);
          apr_pkg::A_FB: fb_q <= 16'(wmerge(32'(fb_q), wdata_q, wstrb_q));
          apr_pkg::A_TIDX: tidx_q <= 4'(wmerge(32'(tidx_q), wdata_q, wstrb_q));
          default: ;
        endcase
      end
    end
  end

  apr_table_mem u_tbl (
    .aclk(aclk),
    .we(wr_fire && waddr_q == apr_pkg::A_TDAT),
    .waddr(tidx_q),
    .wdata(wdata_q),
    .raddr_a(arg),
    .raddr_b(arg2),
    .rdata_a(mem_a),
    .rdata_b(mem_b)
  );

  // command decode once table data is valid
  always_comb begin
    start_ev = '0;
    halt_ev = '0;
    spd_ev = '0;
    dst_ev = '0;
    jog_ev = '0;
    new_tgt[0] = mem_a;
    new_tgt[1] = mem_a;
    err_entry_ev = 1'b0;
    err_range_ev = 1'b0;
    rst_go = 1'b0;
    if (l2_q) begin
      case (op)
        apr_pkg::OP_TABLE: begin
          if (!entry_ok(arg)) err_entry_ev = 1'b1;
          else if (!pulse_ok(abs_en, mem_a, fb_q)) err_range_ev = 1'b1;
          else start_ev[ax] = 1'b1;
        end
        apr_pkg::OP_DIRECT: begin
          new_tgt[ax] = tgt_reg_q;
          if (!pulse_ok(abs_en, tgt_reg_q, fb_q)) err_range_ev = 1'b1;
          else start_ev[ax] = 1'b1;
        end
        apr_pkg::OP_DUAL: begin
          new_tgt[1] = mem_b;
          if (!entry_ok(arg) || !entry_ok(arg2)) err_entry_ev = 1'b1;
          else if (!pulse_ok(abs_en, mem_a, fb_q) || !pulse_ok(abs_en, mem_b, fb_q)) begin
            err_range_ev = 1'b1;
          end else start_ev = '1;
        end
        apr_pkg::OP_HOME: begin
          new_tgt[ax] = '0;
          start_ev[ax] = 1'b1;
        end
        apr_pkg::OP_JOG: jog_ev[ax] = 1'b1;
        apr_pkg::OP_RESTORE: rst_go = rst_state_q == apr_pkg::R_IDLE;
        apr_pkg::OP_HALT: halt_ev[ax] = 1'b1;
        apr_pkg::OP_SPEED: spd_ev[ax] = 1'b1;
        apr_pkg::OP_DEST: begin
          new_tgt[ax] = tgt_reg_q;
          if (!pulse_ok(abs_en, tgt_reg_q, fb_q)) err_range_ev = 1'b1;
          else dst_ev[ax] = 1'b1;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) home_mth_q <= '0;
    else if (l2_q && op == apr_pkg::OP_HOME) home_mth_q <= arg;
  end

  // per-axis motion: steps by speed toward target each cycle
  for (genvar g = 0; g < NA; g++) begin : g_axis
    logic signed [32:0] diff;
    logic [32:0] mag;
    assign diff = 33'(signed'(tgt_q[g])) - 33'(signed'(pos_q[g]));
    assign mag = diff[32] ? 33'(-diff) : 33'(diff);
    assign clr_done[g] = wr_stat && wdata_q[apr_pkg::ST_DONE + g];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pos_q[g] <= '0;
        tgt_q[g] <= '0;
        spd_q[g] <= '0;
        run_q[g] <= 1'b0;
        jog_q[g] <= 1'b0;
        jog_rev_q[g] <= 1'b0;
        done_q[g] <= 1'b0;
      end else begin
        if (clr_done[g]) done_q[g] <= 1'b0;
        if (run_q[g]) begin
          if (jog_q[g]) begin
            pos_q[g] <= jog_rev_q[g] ? pos_q[g] - spd_q[g] : pos_q[g] + spd_q[g];
          end else if (mag <= 33'(spd_q[g])) begin
            pos_q[g] <= tgt_q[g];
            run_q[g] <= 1'b0;
            done_q[g] <= 1'b1;
          end else begin
            pos_q[g] <= diff[32] ? pos_q[g] - spd_q[g] : pos_q[g] + spd_q[g];
          end
          if (spd_ev[g]) spd_q[g] <= spd_reg_q;
          if (dst_ev[g] && !jog_q[g]) tgt_q[g] <= new_tgt[g];
        end
        if (rst_load && rst_axis_q == 1'(g)) begin
          pos_q[g] <= abs_shift_q;
          run_q[g] <= 1'b0;
        end else if (halt_ev[g]) begin
          run_q[g] <= 1'b0;
          jog_q[g] <= 1'b0;
        end else if (start_ev[g] || jog_ev[g]) begin
          tgt_q[g] <= new_tgt[g];
          spd_q[g] <= spd_reg_q;
          run_q[g] <= 1'b1;
          jog_q[g] <= jog_ev[g];
          jog_rev_q[g] <= arg[0];
          done_q[g] <= 1'b0;
        end
      end
    end
  end

  // restore sequence: servo gap, then sixteen two-bit handshake steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_state_q <= apr_pkg::R_IDLE;
      soff_cnt_q <= '0;
      step_q <= '0;
      abs_shift_q <= '0;
      rst_axis_q <= 1'b0;
      abs_xfer_mode_out <= 1'b0;
      abs_request_out <= 1'b0;
    end else begin
      case (rst_state_q)
        apr_pkg::R_IDLE: if (rst_go) begin
          rst_axis_q <= ax;
          soff_cnt_q <= 32'(SOFF_CYCLES - 1);
          step_q <= '0;
          rst_state_q <= apr_pkg::R_SOFF;
        end
        apr_pkg::R_SOFF: if (soff_cnt_q == '0) begin
          abs_xfer_mode_out <= 1'b1;
          abs_request_out <= 1'b1;
          rst_state_q <= apr_pkg::R_REQ;
        end else soff_cnt_q <= soff_cnt_q - 32'h1;
        apr_pkg::R_REQ: if (abs_data_ready_in) begin
          abs_shift_q <= {abs_data_hi_in, abs_data_lo_in, abs_shift_q[31:2]};
          abs_request_out <= 1'b0;
          rst_state_q <= apr_pkg::R_REL;
        end
        apr_pkg::R_REL: if (!abs_data_ready_in) begin
          if (step_q == apr_pkg::STEP_LAST) begin
            abs_xfer_mode_out <= 1'b0;
            rst_state_q <= apr_pkg::R_LOAD;
          end else begin
            step_q <= step_q + 5'h1;
            abs_request_out <= 1'b1;
            rst_state_q <= apr_pkg::R_REQ;
          end
        end
        apr_pkg::R_LOAD: rst_state_q <= apr_pkg::R_IDLE;
        default: rst_state_q <= apr_pkg::R_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) servo_enable_out <= 1'b0;
    else begin
      servo_enable_out <= ctrl_q[apr_pkg::CTRL_SERVO]
                          && rst_state_q != apr_pkg::R_SOFF;
    end
  end

  // sticky status; a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_entry_q <= 1'b0;
      err_range_q <= 1'b0;
      rst_done_q <= 1'b0;
    end else begin
      err_entry_q <= err_entry_ev || (err_entry_q && !(wr_stat && wdata_q[apr_pkg::ST_ERR_ENTRY]));
      err_range_q <= err_range_ev || (err_range_q && !(wr_stat && wdata_q[apr_pkg::ST_ERR_RANGE]));
      rst_done_q <= rst_load
                    || (rst_done_q && !rst_go && !(wr_stat && wdata_q[apr_pkg::ST_RST_DONE]));
    end
  end

  // read path
  always_comb begin
    rd_d = '0;
    rd_ok = 1'b1;
    case (araddr)
      apr_pkg::A_CTRL: rd_d = 32'(ctrl_q);
      apr_pkg::A_CMD: rd_d = 32'(cmd_q);
      apr_pkg::A_STAT: begin
        rd_d[apr_pkg::ST_BUSY +: NA] = run_q;
        rd_d[apr_pkg::ST_RST_BUSY] = rst_state_q != apr_pkg::R_IDLE;
        rd_d[apr_pkg::ST_RST_DONE] = rst_done_q;
        rd_d[apr_pkg::ST_ERR_ENTRY] = err_entry_q;
        rd_d[apr_pkg::ST_ERR_RANGE] = err_range_q;
        rd_d[apr_pkg::ST_DONE +: NA] = done_q;
        rd_d[apr_pkg::ST_HOME_LSB +: 4] = home_mth_q;
      end
      apr_pkg::A_ABS: rd_d = abs_shift_q;
      apr_pkg::A_TGT: rd_d = tgt_reg_q;
      apr_pkg::A_SPD: rd_d = spd_reg_q;
      apr_pkg::A_FB: rd_d = 32'(fb_q);
      apr_pkg::A_POS1: rd_d = pos_q[0];
      apr_pkg::A_POS2: rd_d = pos_q[1];
      apr_pkg::A_TIDX: rd_d = 32'(tidx_q);
      apr_pkg::A_TDAT: rd_d = '0;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= apr_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_d;
      rresp <= rd_ok ? apr_pkg::RESP_OKAY : apr_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  req_in_mode_a: assert property (abs_request_out |-> abs_xfer_mode_out)
    else $error("request outside transfer mode");
  mode_start_a: assert property (
    $rose(abs_xfer_mode_out) |-> abs_request_out && $past(rst_state_q) == apr_pkg::R_SOFF)
    else $error("transfer mode began without request");
  req_hold_a: assert property (
    abs_request_out && !abs_data_ready_in |=> abs_request_out)
    else $error("request dropped before ready");
  req_drop_a: assert property (
    abs_request_out && abs_data_ready_in |=> !abs_request_out
      ##0 abs_shift_q[31:30] == $past({abs_data_hi_in, abs_data_lo_in}))
    else $error("data pair not latched on ready");
  servo_gap_a: assert property (rst_go |=> ##1 !servo_enable_out)
    else $error("servo not dropped for restore");
  servo_off_a: assert property (!ctrl_q[apr_pkg::CTRL_SERVO] |=> !servo_enable_out)
    else $error("servo on without enable");
  range_a: assert property (
    $rose(run_q[ax]) && !jog_q[ax] && op != apr_pkg::OP_HOME
      |-> pulse_ok(abs_en, tgt_q[ax], fb_q))
    else $error("start beyond pulse range");
  entry_a: assert property (
    l2_q && op == apr_pkg::OP_TABLE && !entry_ok(arg) |=> err_entry_q && !$rose(run_q[ax]))
    else $error("bad entry not refused");
  halt_a: assert property (halt_ev[0] && !rst_load |=> !run_q[0])
    else $error("halt did not stop axis");
endmodule : apr_axis_ctrl

// File: rtl/apr_pkg.sv
// constants, register map and types of the absolute position restore axis controller
// assumes a 100 MHz aclk and an AXI4-Lite register bus with 8-bit addresses
package apr_pkg;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CMD = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_ABS = 8'h0c;
  localparam logic [7:0] A_TGT = 8'h10;
  localparam logic [7:0] A_SPD = 8'h14;
  localparam logic [7:0] A_FB = 8'h18;
  localparam logic [7:0] A_POS1 = 8'h1c;
  localparam logic [7:0] A_POS2 = 8'h20;
  localparam logic [7:0] A_TIDX = 8'h24;
  localparam logic [7:0] A_TDAT = 8'h28;
  // ctrl bits
  localparam int CTRL_SERVO = 0;
  localparam int CTRL_ABS_EN = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  // cmd fields
  localparam int OP_LSB = 0;
  localparam int AXIS_BIT = 4;
  localparam int ARG_LSB = 8;
  localparam int ARG2_LSB = 12;
  localparam logic [3:0] OP_TABLE = 4'h1;
  localparam logic [3:0] OP_DIRECT = 4'h2;
  localparam logic [3:0] OP_DUAL = 4'h3;
  localparam logic [3:0] OP_HOME = 4'h4;
  localparam logic [3:0] OP_JOG = 4'h5;
  localparam logic [3:0] OP_RESTORE = 4'h6;
  localparam logic [3:0] OP_HALT = 4'h7;
  localparam logic [3:0] OP_SPEED = 4'h8;
  localparam logic [3:0] OP_DEST = 4'h9;
  // status bits, 0..1 busy and 6..7 done per axis
  localparam int ST_BUSY = 0;
  localparam int ST_RST_BUSY = 2;
  localparam int ST_RST_DONE = 3;
  localparam int ST_ERR_ENTRY = 4;
  localparam int ST_ERR_RANGE = 5;
  localparam int ST_DONE = 6;
  localparam int ST_HOME_LSB = 8;
  // preset table
  localparam int TBL_DEPTH = 10;
  localparam logic [3:0] ENTRY_MIN = 4'h1;
  localparam logic [3:0] ENTRY_MAX = 4'ha;
  // transfer: two bits per step
  localparam int ABS_STEPS = 16;
  localparam logic [4:0] STEP_LAST = 5'(ABS_STEPS - 1);
  // pulse range around origin in feedback revolutions
  localparam int RANGE_NEG = 32678;
  localparam int RANGE_POS = 32768;
  localparam logic [15:0] FB_RST = 16'h2000;
  // timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SOFF_MS = 20;
  localparam int SOFF_CYC = SOFF_MS * (CLK_HZ / 1000);
  localparam int NAXES = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {R_IDLE, R_SOFF, R_REQ, R_REL, R_LOAD} apr_rst_state_t;
endpackage : apr_pkg

// File: rtl/apr_table_mem.sv
// preset positioning table, entries 1..10, two registered read ports
// assumes callers give entry numbers; out-of-range writes are dropped
`timescale 1ns/10ps
module apr_table_mem (
  input wire logic aclk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] raddr_a,
  input wire logic [3:0] raddr_b,
  output logic [31:0] rdata_a,
  output logic [31:0] rdata_b
);
  logic [31:0] mem [apr_pkg::TBL_DEPTH];

  always_ff @(posedge aclk) begin
    if (we && waddr >= apr_pkg::ENTRY_MIN && waddr <= apr_pkg::ENTRY_MAX) begin
      mem[waddr - apr_pkg::ENTRY_MIN] <= wdata;
    end
  end

  always_ff @(posedge aclk) begin
    rdata_a <= mem[raddr_a - apr_pkg::ENTRY_MIN];
    rdata_b <= mem[raddr_b - apr_pkg::ENTRY_MIN];
  end
endmodule : apr_table_mem
